// [verilog/sre_core.sv]
// Security register erase command engine behind the SPI pins.
// Assumes SPI mode 0, clock sampled here, pins asynchronous to core_clk.
// What this block does
// R1: Three 256-byte registers, each erased alone
// R2: Erase taken only with write enable set
// R3: Host sends 44h then 24-bit address
// R4: Address picks register one, two, three
// R5: Chip select rises after bit 32
// R6: Self-timed erase, status register 1 reads (05h) still answered
// R7: Busy bit high throughout the erase
// R8: Write enable latch cleared at completion
// R9: Locked register erase commands are ignored
// R10: Bits sampled on rising clock, MSB first
// R11: Erased register reads all FFh, others kept
`timescale 1ns/100ps
`default_nettype none
module sre_core
  import sre_pkg::*;
#(
  parameter int T_SE_CYC = SRE_T_SE_CYC
)
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // SPI pins
  input  wire logic       spi_cs_n,
  input  wire logic       spi_clk,
  input  wire logic       spi_di,
  output logic            spi_do,
  output logic            spi_do_oe,
  // One-time lock bits, one per register
  input  wire logic [2:0] security_lock_bits,
  // Status
  output logic            busy,
  output logic            write_enable_latch,
  output logic [1:0]      erase_sel
);
  // =======================================================
  // Register array, reached through its carrier
  sre_arr_if arr_if ();
  sre_array u_array (.core_clk(core_clk), .reset_n(reset_n), .arr(arr_if));

  // =======================================================
  // State
  typedef struct packed {
    logic [2:0]  sy1;
    logic [2:0]  sy2;
    sre_state_e  fsm;
    logic        bsy;
    logic        sck_d;
    logic        cs_d;
    logic [31:0] sh;
    logic [5:0]  cnt;
    logic [31:0] tmr;
    logic        wr_en;
    logic [1:0]  sel;
    logic        clr;
    logic [7:0]  out;
    logic        oe;
    logic        rd_sr;
  } sre_core_s;
  sre_core_s st;
  sre_core_s next_st;

  // Only the second synchroniser stage is read by the logic
  wire logic        cs_n      = st.sy2[SRE_PIN_CS];
  wire logic        sck       = st.sy2[SRE_PIN_CLK];
  wire logic        di        = st.sy2[SRE_PIN_DI];
  wire logic        sck_rise  = sck && !st.sck_d;
  wire logic        sck_fall  = !sck && st.sck_d;
  wire logic [31:0] nsh       = {st.sh[30:0], di};
  // Lock bits as they stand in the second status byte
  wire logic [7:0]  lock_byte = {5'h0, security_lock_bits} << SRE_SR2_LOCK_LO;
  logic [7:0]       sr;

  always_comb
  begin
    next_st       = st;
    // Two flip-flops on every pin before any logic looks at it
    next_st.sy1   = {spi_cs_n, spi_clk, spi_di};
    next_st.sy2   = st.sy1;
    next_st.sck_d = sck;
    next_st.cs_d  = cs_n;
    next_st.clr   = 1'b0;
    sr                  = '0;
    sr[SRE_SR1_BUSY]    = st.bsy;
    sr[SRE_SR1_WRLATCH] = st.wr_en;
    unique case (st.fsm)
      SRE_IDLE:
      begin
        if (!cs_n)
        begin
          next_st.fsm   = SRE_SHIFT;
          next_st.cnt   = '0;
          next_st.rd_sr = 1'b0;
        end
      end
      SRE_SHIFT:
      begin
        // R10: sample on rising edge
        if (!cs_n && sck_rise)
        begin
          next_st.sh = nsh;
          // Saturates, so an overlong frame never looks like 32 bits
          if (st.cnt != '1)
            next_st.cnt = st.cnt + 6'd1;
        end
        if (!cs_n && sck_rise && st.cnt == 6'(SRE_OPC_BITS - 1))
        begin
          if (nsh[7:0] == SRE_OPC_RDSR1 || nsh[7:0] == SRE_OPC_RDSR2)
          begin
            next_st.rd_sr = 1'b1;
            next_st.out   = (nsh[7:0] == SRE_OPC_RDSR1) ? sr : lock_byte;
          end
          // R2: only erase needs write enable
          else if (nsh[7:0] != SRE_OPC_ERASE && nsh[7:0] != SRE_OPC_WREN)
            next_st.fsm = SRE_SKIP;
          else if (nsh[7:0] == SRE_OPC_ERASE && !st.wr_en)
            next_st.fsm = SRE_SKIP;
        end
        // First falling edge after the opcode only turns the pin on
        if (st.rd_sr && sck_fall)
        begin
          next_st.oe = 1'b1;
          if (st.oe)
            next_st.out = {st.out[6:0], 1'b0};
        end
        if (cs_n)
        begin
          next_st.fsm = SRE_IDLE;
          next_st.oe  = 1'b0;
          if (st.cnt == 6'(SRE_OPC_BITS) && st.sh[7:0] == SRE_OPC_WREN)
            next_st.wr_en = 1'b1;
          // R5: exactly 32 bits, else discarded
          if (st.cnt == 6'(SRE_CMD_BITS) && st.sh[31:24] == SRE_OPC_ERASE && st.wr_en)
          begin
            // R4: address decode
            if (st.sh[23:16] == SRE_ADDR_HI && st.sh[11:8] == SRE_ADDR_MID &&
                st.sh[15:12] >= 4'h1 && st.sh[15:12] <= 4'h3)
            begin
              // R9: lock bit vetoes erase
              if (!security_lock_bits[st.sh[13:12] - 2'd1])
              begin
                // R6: start self-timed erase
                next_st.fsm = SRE_BUSY;
                next_st.sel = st.sh[13:12];
                next_st.tmr = 32'(T_SE_CYC);
              end
            end
          end
        end
      end
      SRE_SKIP:
      begin
        if (cs_n)
          next_st.fsm = SRE_IDLE;
      end
      SRE_BUSY:
      begin
        // R6: status register 1 reads (05h) still served in busy
        if (!cs_n && !st.cs_d)
        begin
          if (sck_rise && st.cnt != 6'(SRE_OPC_BITS))
          begin
            next_st.sh  = nsh;
            next_st.cnt = st.cnt + 6'd1;
          end
          if (st.cnt == 6'(SRE_OPC_BITS) && st.sh[7:0] == SRE_OPC_RDSR1 && sck_fall)
          begin
            next_st.oe  = 1'b1;
            next_st.out = st.rd_sr ? {st.out[6:0], 1'b0} : sr;
            next_st.rd_sr = 1'b1;
          end
        end
        else
        begin
          next_st.cnt   = '0;
          next_st.oe    = 1'b0;
          next_st.rd_sr = 1'b0;
        end
        // R7: busy held until timer expires
        next_st.tmr = st.tmr - 32'd1;
        if (st.tmr == 32'd1)
        begin
          next_st.clr   = 1'b1;
          next_st.fsm   = SRE_IDLE;
          // R8: clear write enable latch
          next_st.wr_en = 1'b0;
          next_st.oe    = 1'b0;
        end
      end
      default:
        next_st.fsm = SRE_IDLE;
    endcase
    // Busy is kept as a flop of its own so the output needs no decode
    next_st.bsy = (next_st.fsm == SRE_BUSY);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st                 <= '0;
      st.fsm             <= SRE_IDLE;
      // Idle levels of the pins, so no false edge follows reset
      st.sy1[SRE_PIN_CS] <= 1'b1;
      st.sy2[SRE_PIN_CS] <= 1'b1;
      st.cs_d            <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign arr_if.clr         = st.clr;
  assign arr_if.sel         = st.sel;
  // The low shift byte picks the byte watched after a clear: the don't-care low address byte, or the opcode of the last frame taken during busy
  assign arr_if.rd_idx      = st.sh[7:0];
  assign spi_do             = st.out[7];
  assign spi_do_oe          = st.oe;
  assign busy               = st.bsy;
  assign write_enable_latch = st.wr_en;
  assign erase_sel          = st.sel;

  // =======================================================
  // Checks
  // R8: latch cleared at end
  a_end_clears_latch: // R8
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(busy) |-> !write_enable_latch)
    else $error("write enable latch still set after erase");
  // R2: erase needs latch
  a_erase_needs_latch: // R2
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(busy) |-> $past(write_enable_latch))
    else $error("erase began without write enable");
  // R4: register always selected
  a_busy_sel_valid: // R4
    assert property (@(posedge core_clk) disable iff (!reset_n)
      busy |-> (erase_sel != 2'd0))
    else $error("busy with no register");
  // R9: lock bit vetoes
  a_locked_no_erase: // R9
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(busy) |-> !security_lock_bits[erase_sel - 2'd1])
    else $error("locked register erased");
  // R6: start on select rise
  a_start_on_cs: // R6
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(busy) |-> $past(cs_n))
    else $error("erase began with select low");
  // R5: exactly 32 bits
  a_bits_exact: // R5
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(busy) |-> ($past(st.cnt) == 6'(SRE_CMD_BITS)))
    else $error("bad bit count");
  // R11: clear at end
  a_clr_at_end: // R11
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(busy) |-> st.clr)
    else $error("no clear at end");
  // R11: erased byte reads ones
  a_erased_ones: // R11
    assert property (@(posedge core_clk) disable iff (!reset_n)
      st.clr |=> (arr_if.rd_data == SRE_ERASED))
    else $error("erased byte not all ones");
  // R7: busy holds on
  a_busy_holds: // R7
    assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(busy) |-> busy[*2])
    else $error("busy dropped early");
endmodule : sre_core
`default_nettype wire

// [verilog/sre_pkg.sv]
// Constants for the security register erase block.
// Assumes one core clock at 25 MHz; the SPI pins are asynchronous to it.
`default_nettype none
package sre_pkg;
  // =======================================================
  // Command and address decode
  localparam logic [7:0] SRE_OPC_ERASE   = 8'h44;
  localparam logic [7:0] SRE_OPC_WREN    = 8'h06;
  localparam logic [7:0] SRE_OPC_RDSR1   = 8'h05;
  localparam logic [7:0] SRE_OPC_RDSR2   = 8'h35;
  localparam logic [7:0] SRE_ADDR_HI     = 8'h00;
  localparam logic [3:0] SRE_ADDR_MID    = 4'h0;
  localparam int         SRE_CMD_BITS    = 32;
  localparam int         SRE_OPC_BITS    = 8;
  localparam int         SRE_NUM_REGS    = 3;
  localparam int         SRE_REG_BYTES   = 256;
  localparam logic [7:0] SRE_ERASED      = 8'hff;
  // =======================================================
  // Timing: erase time in microseconds at 25 MHz
  localparam int         SRE_CLK_MHZ     = 25;
  localparam int         SRE_T_SE_US     = 1000;
  localparam int         SRE_T_SE_CYC    = SRE_T_SE_US * SRE_CLK_MHZ;
  // =======================================================
  // Status bit positions
  localparam int         SRE_SR1_BUSY    = 0;
  localparam int         SRE_SR1_WRLATCH = 1;
  localparam int         SRE_SR2_LOCK_LO = 3;
  // =======================================================
  // Pin positions inside the synchroniser words
  localparam int         SRE_PIN_CS      = 2;
  localparam int         SRE_PIN_CLK     = 1;
  localparam int         SRE_PIN_DI      = 0;
  // =======================================================
  // Command decoder states, one-hot
  typedef enum logic [3:0] {
    SRE_IDLE  = 4'b0001,
    SRE_SHIFT = 4'b0010,
    SRE_SKIP  = 4'b0100,
    SRE_BUSY  = 4'b1000
  } sre_state_e;
endpackage : sre_pkg
`default_nettype wire

// [verilog/sre_arr_if.sv]
// Carrier between the command engine and the register array.
// Assumes both ends run on core_clk.
`timescale 1ns/100ps
`default_nettype none
interface sre_arr_if;
  logic       clr;
  logic [1:0] sel;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  modport ctl (output clr, output sel, output rd_idx, input rd_data);
  modport arr (input clr, input sel, input rd_idx, output rd_data);
endinterface : sre_arr_if
`default_nettype wire

// [verilog/sre_array.sv]
// Three 256-byte security registers held in flip-flops.
// Assumes clr is a one-cycle pulse with sel 1 to 3.
`timescale 1ns/100ps
`default_nettype none
module sre_array
  import sre_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command side
  sre_arr_if.arr   arr
);
  typedef struct packed {
    logic [SRE_NUM_REGS-1:0][SRE_REG_BYTES-1:0][7:0] mem;
  } sre_arr_s;
  sre_arr_s st;
  sre_arr_s next_st;

  always_comb
  begin
    next_st = st;
    // R1: each register erased alone
    for (int r = 0; r < SRE_NUM_REGS; r++)
    begin
      // R11: selected register goes to all ones
      if (arr.clr && (arr.sel == 2'(r + 1)))
      begin
        for (int b = 0; b < SRE_REG_BYTES; b++)
        begin
          next_st.mem[r][b] = SRE_ERASED;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '1;
    else
      st <= next_st;
  end

  assign arr.rd_data = (arr.sel == 2'd0) ? SRE_ERASED : st.mem[arr.sel - 2'd1][arr.rd_idx];
endmodule : sre_array
`default_nettype wire

// [verif/sre_host.sv]
// Host SPI controller model, mode 0, link clock of 320 ns.
// Assumes core_clk at 25 MHz; the link clock stands low outside frames.
`timescale 1ns/100ps
`default_nettype none
module sre_host (
  // Clock
  input  wire logic core_clk,
  // SPI pins
  output var logic  spi_cs_n,
  output var logic  spi_clk,
  output var logic  spi_di,
  input  wire logic spi_do
);
  initial
  begin
    spi_cs_n = 1'b1;
    spi_clk  = 1'b0;
    spi_di   = 1'b0;
  end
  // ==========================================
  // One frame, MSB first; rd keeps the last eight bits seen on spi_do
  task automatic frame(input logic [39:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    // opcode then address, data set while the clock is low
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_di <= bits[i];
      repeat (4) @(posedge core_clk);
      spi_clk <= 1'b1;
      rd = {rd[6:0], spi_do};
      repeat (4) @(posedge core_clk);
      spi_clk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    // select released after the last bit; data line no longer holds its value
    spi_cs_n <= 1'b1;
    spi_di   <= ~spi_di;
    repeat (8) @(posedge core_clk);
  endtask : frame
endmodule : sre_host
`default_nettype wire

// [verif/security_register_erase_test.sv]
// Self-checking bench for the security register erase engine.
// Assumes sre_core holds the register array; sre_host drives the pins.
`timescale 1ns/100ps
`default_nettype none
module security_register_erase_test;
  import sre_pkg::*;
  // Short erase time, still longer than a status read frame
  localparam int T_SE = 400;
  logic       core_clk;
  logic       reset_n;
  logic       spi_cs_n;
  logic       spi_clk;
  logic       spi_di;
  logic       spi_do;
  logic [2:0] lock;
  logic       busy;
  logic       wr_latch;
  logic [1:0] sel;
  logic [7:0] rd;
  int         busy_len;
  int         err_count;
  int         checked;
  sre_core #(.T_SE_CYC(T_SE)) sre_core_i (
    .core_clk(core_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n),
    .spi_clk(spi_clk), .spi_di(spi_di), .spi_do(spi_do), .spi_do_oe(),
    .security_lock_bits(lock), .busy(busy), .write_enable_latch(wr_latch),
    .erase_sel(sel));
  sre_host host_i (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
    .spi_di(spi_di), .spi_do(spi_do));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (busy === 1'b1)
      busy_len <= busy_len + 1;
  // ==========================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  function automatic logic [23:0] adr(input logic [3:0] r);
    return {SRE_ADDR_HI, r, SRE_ADDR_MID, 8'h5a};
  endfunction : adr
  task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int n);
    host_i.frame({8'h00, opc, a}, n, rd);
  endtask : cmd
  // ==========================================
  // Scenarios
  task automatic erase_ok(input logic [1:0] r);
    cmd(8'h00, {16'h0000, SRE_OPC_WREN}, 8);
    chk(8'(wr_latch), 8'h01);
    busy_len = 0;
    cmd(SRE_OPC_ERASE, adr({2'b00, r}), 32);
    chk(8'(busy), 8'h01);
    chk(8'(sel), 8'(r));
    cmd(8'h00, {SRE_OPC_RDSR1, 8'h00}, 16);
    chk(8'(rd[1:0]), 8'h03);
    for (int i = 0; i < T_SE + 20 && busy !== 1'b0; i++)
      @(posedge core_clk);
    chk(8'(busy_len >= T_SE - 1 && busy_len <= T_SE + 1), 8'h01);
    chk(8'(wr_latch), 8'h00);
  endtask : erase_ok
  task automatic refused(input logic [23:0] a, input int n, input logic w);
    cmd(SRE_OPC_ERASE, a, n);
    repeat (20) @(posedge core_clk);
    chk(8'(busy), 8'h00);
    chk(8'(wr_latch), 8'(w));
  endtask : refused
  // Erase opcode with a good address, but the frame is cut short or overlong
  task automatic refused_raw(input logic [39:0] bits, input int n);
    host_i.frame(bits, n, rd);
    repeat (20) @(posedge core_clk);
    chk(8'(busy), 8'h00);
    chk(8'(wr_latch), 8'h01);
  endtask : refused_raw
  // ==========================================
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    lock = 3'b000;
    busy_len = 0;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk({busy, wr_latch, sel}, 8'h00);
    for (int r = 1; r <= SRE_NUM_REGS; r++)
      erase_ok(2'(r));
    refused(adr(4'h1), 32, 1'b0);
    cmd(8'h00, {16'h0000, SRE_OPC_WREN}, 8);
    refused({8'h01, 16'h1000}, 32, 1'b1);
    refused({8'h00, 16'h4000}, 32, 1'b1);
    refused({8'h00, 16'h1100}, 32, 1'b1);
    refused(adr(4'h0), 32, 1'b1);
    refused_raw({9'h000, SRE_OPC_ERASE, 23'h00102d}, 31);
    refused_raw({7'h00, SRE_OPC_ERASE, adr(4'h2), 1'b0}, 33);
    refused(adr(4'h7), 32, 1'b1);
    @(posedge core_clk);
    lock <= 3'b010;
    cmd(8'h00, {SRE_OPC_RDSR2, 8'h00}, 16);
    chk(8'(rd[5:3]), 8'h02);
    refused(adr(4'h2), 32, 1'b1);
    erase_ok(2'd1);
    wrap_up();
  end
  initial
  begin
    #2ms;
    err_count++;
    wrap_up();
  end
endmodule : security_register_erase_test
`default_nettype wire
